// [test/arrow_entry_asserts.sv]
// Checker for the arrow-switch entry block, watching only its ports.
// Assumes binding into arrow_switch_entry with its parameters handed on.
`timescale 1ns/1ps
`default_nettype none
module arrow_entry_asserts #(
  parameter bit SINK_OUTPUT        = 1'b1,
  parameter bit DISPLAY_DATA_NEG   = 1'b1,
  parameter bit DISPLAY_STROBE_NEG = 1'b0,
  parameter bit TWO_SETS           = 1'b0,
  parameter int SCAN_CYCLES        = arrow_entry_pkg::SCAN_CYCLES
) (
  input wire logic                                     sys_clk_in,
  input wire logic                                     rst_in,
  input wire logic                                     command_in,
  input wire arrow_entry_pkg::switch_s                 switch_in,
  input wire arrow_entry_pkg::latched_segment_output_s display_pins_out,
  input wire logic [15:0]                              edited_value_word_out,
  input wire logic [1:0]                               selected_digit_out,
  input wire logic [2:0]                               config_code_out,
  input wire logic                                     refresh_done_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  logic [31:0] hi_cnt_ff;

  function automatic int dig(input logic [15:0] v, input logic [1:0] i);
    return (int'(v) / (10 ** int'(i))) % 10;
  endfunction

  // Cycles since the command input last rose, saturating
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !command_in)
      hi_cnt_ff <= 32'h00000000;
    else if (hi_cnt_ff != 32'hffffffff)
      hi_cnt_ff <= hi_cnt_ff + 32'h00000001;
  end

  AST_CFG_CODE: assert property (config_code_out ==
    {TWO_SETS, DISPLAY_DATA_NEG ^ SINK_OUTPUT, DISPLAY_STROBE_NEG ^ SINK_OUTPUT})
    else $error("config code wrong");
  AST_RANGE: assert property (edited_value_word_out <= 16'h270f)
    else $error("value above limit");
  AST_FREEZE: assert property (!command_in |=> $stable(edited_value_word_out)
    && $stable(selected_digit_out) && $stable(display_pins_out)) else $error("moved while off");
  AST_RESTART_IDLE: assert property ($rose(command_in) |=> display_pins_out ==
    {{4{DISPLAY_STROBE_NEG}}, {4{DISPLAY_DATA_NEG}}}) else $error("pins not idle");
  AST_ONE_STROBE: assert property ($onehot0(display_pins_out.strobe ^
    {4{DISPLAY_STROBE_NEG}})) else $error("several strobes active");
  AST_SEL_STEP: assert property ($changed(selected_digit_out) && !$past(rst_in) |->
    (selected_digit_out == $past(selected_digit_out) - 2'h1 && $past(switch_in.lower)) ||
    (selected_digit_out == $past(selected_digit_out) + 2'h1 && $past(switch_in.higher)))
    else $error("selection step wrong");
  AST_VAL_CAUSE: assert property ($changed(edited_value_word_out) && !$past(rst_in) |->
    $past(switch_in.inc) != $past(switch_in.dec)) else $error("value changed without key");
  AST_INC: assert property ($changed(edited_value_word_out) && !$past(rst_in)
    && $past(switch_in.inc) |-> dig(edited_value_word_out, $past(selected_digit_out)) ==
    (dig($past(edited_value_word_out), $past(selected_digit_out)) + 1) % 10)
    else $error("increment wrong");
  AST_DEC: assert property ($changed(edited_value_word_out) && !$past(rst_in)
    && $past(switch_in.dec) |-> dig(edited_value_word_out, $past(selected_digit_out)) ==
    (dig($past(edited_value_word_out), $past(selected_digit_out)) + 9) % 10)
    else $error("decrement wrong");
  AST_DONE: assert property (refresh_done_out |-> hi_cnt_ff > 32'(11 * SCAN_CYCLES)
    ##1 !refresh_done_out) else $error("refresh done early or long");
endmodule // arrow_entry_asserts
`default_nettype wire

// [test/arrow_switch_entry_tb.sv]
// Self-checking bench for the arrow-switch entry block.
// Assumes a short scan period and a one-set latching display model.
`timescale 1ns/1ps
`default_nettype none
module arrow_switch_entry_tb;
  localparam int S = 4;
  logic                                     sys_clk_in;
  logic                                     rst_in;
  logic                                     command_in;
  arrow_entry_pkg::switch_s                 sw;
  arrow_entry_pkg::latched_segment_output_s pins;
  logic [15:0]                              value;
  logic [1:0]                               sel;
  logic [2:0]                               code;
  logic                                     done;
  arrow_entry_pkg::digits_t                 shown;
  int fails;
  int compares;
  int cyc;
  int n;
  int es;
  int exp_d[4];
  int on_cnt[4];
  logic [3:0] keys[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc};

  arrow_switch_entry #(.SCAN_CYCLES(S)) arrow_switch_entry_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .command_in(command_in), .switch_in(sw),
    .display_pins_out(pins), .edited_value_word_out(value), .selected_digit_out(sel),
    .config_code_out(code), .refresh_done_out(done));
  seg_display_model #(.DATA_NEG(1'b1), .STROBE_NEG(1'b0)) seg_display_model_inst (
    .sys_clk_in(sys_clk_in), .pins_in(pins), .shown_out(shown));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task give_verdict();
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One clock of watching; strobe lines drive high when active for this display
  task tally();
    @(negedge sys_clk_in);
    for (int i = 0; i < 4; i++)
      on_cnt[i] += int'(pins.strobe[i]);
  endtask

  function automatic logic [15:0] exp_val();
    return 16'(exp_d[3] * 1000 + exp_d[2] * 100 + exp_d[1] * 10 + exp_d[0]);
  endfunction

  // Key held over two scans, then released over two
  task press(input logic [3:0] k);
    @(negedge sys_clk_in);
    sw = arrow_entry_pkg::switch_s'(k);
    repeat (2 * S) @(negedge sys_clk_in);
    sw = '0;
    repeat (2 * S) @(negedge sys_clk_in);
    if (command_in)
      case (k)
        4'h1: exp_d[es] = (exp_d[es] + 1) % 10;
        4'h2: exp_d[es] = (exp_d[es] + 9) % 10;
        4'h4: es = (es + 3) % 4;
        4'h8: es = (es + 1) % 4;
        default: ;
      endcase
    check(value, exp_val());
    check(16'(sel), 16'(es));
  endtask

  initial
  begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    fails = 0;
    compares = 0;
    es = 3;
    exp_d = '{0, 0, 0, 0};
    rst_in = 1'b1;
    command_in = 1'b0;
    sw = '0;
    void'($urandom(13));
    repeat (6) @(negedge sys_clk_in);
    rst_in = 1'b0;
    @(negedge sys_clk_in);
    check(16'(code), 16'h0001);
    check(16'(pins), 16'h000f);
    command_in = 1'b1;
    repeat (10) press(4'h1);
    press(4'h2);
    for (int i = 0; i < 6; i++)
      press(keys[i]);
    repeat (60) press(keys[$urandom % 6]);
    command_in = 1'b0;
    press(4'h1);
    command_in = 1'b1;
    repeat (5 * S) @(negedge sys_clk_in);
    command_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    command_in = 1'b1;
    n = 0;
    on_cnt = '{0, 0, 0, 0};
    while (done !== 1'b1 && n < 400)
    begin
      tally();
      n++;
    end
    check(16'(n >= 11 * S + 1 && n <= 12 * S + 3), 16'h0001);
    // The last step of the refresh stands for one more scan
    repeat (S - 1) tally();
    for (int i = 0; i < 4; i++)
      check(16'(on_cnt[i]), 16'((i == es) ? 3 * S : S));
    for (int i = 0; i < 4; i++)
      check(16'(shown[i]), 16'(exp_d[i]));
    give_verdict();
  end
endmodule // arrow_switch_entry_tb

bind arrow_switch_entry arrow_entry_asserts #(
  .SINK_OUTPUT(SINK_OUTPUT), .DISPLAY_DATA_NEG(DISPLAY_DATA_NEG),
  .DISPLAY_STROBE_NEG(DISPLAY_STROBE_NEG), .TWO_SETS(TWO_SETS), .SCAN_CYCLES(SCAN_CYCLES)
) arrow_entry_asserts_inst (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .command_in(command_in), .switch_in(switch_in),
  .display_pins_out(display_pins_out), .edited_value_word_out(edited_value_word_out),
  .selected_digit_out(selected_digit_out), .config_code_out(config_code_out),
  .refresh_done_out(refresh_done_out));
`default_nettype wire

// [test/seg_display_model.sv]
// Latching BCD display model: keeps one digit per strobe line.
// Assumes pin levels from the entry block, one display set.
`timescale 1ns/1ps
`default_nettype none
module seg_display_model #(
  parameter bit DATA_NEG   = 1'b1,
  parameter bit STROBE_NEG = 1'b0
) (
  input  wire logic                                     sys_clk_in,
  input  wire arrow_entry_pkg::latched_segment_output_s pins_in,
  output arrow_entry_pkg::digits_t                      shown_out
);
  // Follows data while the strobe is active, holds it afterwards
  always_ff @(posedge sys_clk_in)
  begin
    for (int i = 0; i < 4; i++)
      if (pins_in.strobe[i] ^ STROBE_NEG)
        shown_out[i] <= pins_in.bcd ^ {4{DATA_NEG}};
  end
endmodule // seg_display_model
`default_nettype wire

// [verilog/arrow_entry_pkg.sv]
// Shared types, constants and helpers for the arrow-switch entry block.
// Assumes a 200 MHz system clock.
`default_nettype none
package arrow_entry_pkg;

  // Clock and scan timing
  localparam longint unsigned CLK_PERIOD_PS = 64'd5000;
  localparam longint unsigned SCAN_MIN_MS   = 64'd10;
  localparam longint unsigned SCAN_MIN_PS   = SCAN_MIN_MS * 64'd1000000000;
  // Scan must exceed the minimum, so one cycle beyond it
  localparam int SCAN_CYCLES = int'(SCAN_MIN_PS / CLK_PERIOD_PS) + 1;

  // Refresh sequence: three scans per digit, four digits
  localparam int          DIGITS         = 4;
  localparam int          PHASES         = 3;
  localparam logic [3:0]  REFRESH_LAST   = 4'hb;
  localparam logic [3:0]  STEP_RESET     = 4'h0;
  localparam logic [1:0]  PHASE_STROBE   = 2'h1;

  // Digit selection, index 3 is thousands
  localparam logic [1:0]  SEL_RESET      = 2'h3;
  localparam logic [3:0]  DIGIT_MAX      = 4'h9;
  localparam logic [3:0]  DIGIT_ZERO     = 4'h0;
  localparam logic [15:0] VALUE_RESET    = 16'h0000;

  // Configuration code fields
  localparam int CFG_STROBE_BIT = 0;
  localparam int CFG_DATA_BIT   = 1;
  localparam int CFG_SETS_BIT   = 2;
  localparam int CFG_MAX_ONE_SET = 3;

  typedef struct packed {
    logic higher;   // base+3
    logic lower;    // base+2
    logic dec;      // base+1
    logic inc;      // base
  } switch_s;

  typedef struct packed {
    logic [3:0] strobe;  // display_output_base+4..+7
    logic [3:0] bcd;     // display_output_base..+3
  } latched_segment_output_s;

  typedef logic [3:0][3:0] digits_t;

  // Output configuration code from display and output-stage polarity
  function automatic logic [2:0] config_code(input logic sink_out, input logic data_neg,
                                             input logic strobe_neg, input logic two_sets);
    logic [2:0] code;
    code = 3'h0;
    code[CFG_STROBE_BIT] = strobe_neg ^ sink_out;
    code[CFG_DATA_BIT]   = data_neg ^ sink_out;
    code[CFG_SETS_BIT]   = two_sets;
    return code;
  endfunction

  function automatic logic [3:0] digit_inc(input logic [3:0] d);
    return (d >= DIGIT_MAX) ? DIGIT_ZERO : d + 4'h1;
  endfunction

  function automatic logic [3:0] digit_dec(input logic [3:0] d);
    return (d == DIGIT_ZERO || d > DIGIT_MAX) ? DIGIT_MAX : d - 4'h1;
  endfunction

  function automatic logic [15:0] digits_to_bin(input digits_t d);
    logic [15:0] v;
    v = 16'({12'h000, d[3]} * 16'd1000) + 16'({12'h000, d[2]} * 16'd100)
      + 16'({12'h000, d[1]} * 16'd10) + {12'h000, d[0]};
    return v;
  endfunction

  function automatic logic [3:0] one_hot(input logic [1:0] idx);
    return 4'h1 << idx;
  endfunction

endpackage
`default_nettype wire

// [verilog/arrow_switch_entry.sv]
// Arrow-switch decimal entry with multiplexed latching BCD display drive.
// Assumes synchronous switch and command inputs, a BCD-decoding latching display.
`timescale 1ns/1ps
`default_nettype none
module arrow_switch_entry #(
  parameter bit SINK_OUTPUT        = 1'b1,
  parameter bit DISPLAY_DATA_NEG   = 1'b1,
  parameter bit DISPLAY_STROBE_NEG = 1'b0,
  parameter bit TWO_SETS           = 1'b0,
  parameter int SCAN_CYCLES        = arrow_entry_pkg::SCAN_CYCLES
) (
  input  wire logic                                     sys_clk_in,
  input  wire logic                                     rst_in,
  input  wire logic                                     command_in,
  input  wire arrow_entry_pkg::switch_s                 switch_in,
  output arrow_entry_pkg::latched_segment_output_s      display_pins_out,
  output logic [15:0]                                   edited_value_word_out,
  output logic [1:0]                                    selected_digit_out,
  output logic [2:0]                                    config_code_out,
  output logic                                          refresh_done_out
);

  // Output configuration code
  localparam logic [2:0] CFG = arrow_entry_pkg::config_code(SINK_OUTPUT, DISPLAY_DATA_NEG,
                                                            DISPLAY_STROBE_NEG,
                                                            TWO_SETS);
  localparam logic DATA_MIS   = CFG[arrow_entry_pkg::CFG_DATA_BIT];
  localparam logic STROBE_MIS = CFG[arrow_entry_pkg::CFG_STROBE_BIT];

  // Idle pin levels: strobes inactive, data lines at BCD zero
  localparam logic [3:0] STROBE_IDLE_PIN = {4{STROBE_MIS ^ SINK_OUTPUT}};
  localparam logic [3:0] BCD_IDLE_PIN    = {4{DATA_MIS ^ SINK_OUTPUT}};

  generate
    if (TWO_SETS || int'(CFG) > arrow_entry_pkg::CFG_MAX_ONE_SET)
    begin : g_bad_sets
      $error("arrow_switch_entry: only one display set is supported");
    end
    if (SCAN_CYCLES < 1)
    begin : g_bad_scan
      $error("arrow_switch_entry: SCAN_CYCLES must be at least 1");
    end
    if (arrow_entry_pkg::PHASES * arrow_entry_pkg::DIGITS !=
        int'(arrow_entry_pkg::REFRESH_LAST) + 1)
    begin : g_bad_refresh
      $error("arrow_switch_entry: refresh length must be digits times phases");
    end
  endgenerate

  // Scan pacing
  logic scan_tick;

  scan_pacer #(
    .SCAN_CYCLES (SCAN_CYCLES)
  ) u_scan_pacer (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .scan_tick_out (scan_tick)
  );

  // State
  logic                        cmd_prev_ff;
  arrow_entry_pkg::switch_s    sw_prev_ff;
  arrow_entry_pkg::digits_t    digits_ff;
  arrow_entry_pkg::digits_t    nxt_digits;
  logic [1:0]                  sel_ff;
  logic [1:0]                  nxt_sel;
  logic [15:0]                 value_ff;
  logic [3:0]                  step_ff;
  logic [3:0]                  nxt_step;
  arrow_entry_pkg::latched_segment_output_s pins_ff;
  arrow_entry_pkg::latched_segment_output_s nxt_pins;
  logic                        done_ff;

  // Qualifiers
  logic                        restart;
  logic                        advance;
  arrow_entry_pkg::switch_s    press;
  logic [1:0]                  slot;
  logic [1:0]                  phase;
  logic [3:0]                  slot_data;
  logic [3:0]                  strobe_act;

  // A rising command spends its cycle on the restart; a scan tick that lands
  // on it is skipped so the first step never shows stale pins
  assign restart = command_in && !cmd_prev_ff;
  assign advance = command_in && !restart && scan_tick;

  // Rising edge of each switch, judged scan to scan
  assign press = switch_in & ~sw_prev_ff;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cmd_prev_ff <= 1'b0;
    end
    else
    begin
      cmd_prev_ff <= command_in;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      sw_prev_ff <= '0;
    end
    else if (advance)
    begin
      sw_prev_ff <= switch_in;
    end
  end

  // Digit selection
  // Opposite moves in one scan cancel rather than guess an order
  always_comb
  begin
    nxt_sel = sel_ff;
    if (press.lower && !press.higher)
    begin
      nxt_sel = sel_ff - 2'h1;
    end
    else if (press.higher && !press.lower)
    begin
      nxt_sel = sel_ff + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      sel_ff <= arrow_entry_pkg::SEL_RESET;
    end
    else if (advance)
    begin
      sel_ff <= nxt_sel;
    end
  end

  // Digit editing acts on the digit selected before this scan's moves
  // Increment and decrement together leave the digit untouched
  always_comb
  begin
    nxt_digits = digits_ff;
    if (press.inc && !press.dec)
    begin
      nxt_digits[sel_ff] = arrow_entry_pkg::digit_inc(digits_ff[sel_ff]);
    end
    else if (press.dec && !press.inc)
    begin
      nxt_digits[sel_ff] = arrow_entry_pkg::digit_dec(digits_ff[sel_ff]);
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      digits_ff <= '0;
    end
    else if (advance)
    begin
      digits_ff <= nxt_digits;
    end
  end

  // Binary value, never above 9999 since each digit stays 0..9
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      value_ff <= arrow_entry_pkg::VALUE_RESET;
    end
    else if (advance)
    begin
      value_ff <= arrow_entry_pkg::digits_to_bin(nxt_digits);
    end
  end

  // Refresh step: three scans per digit, thousands first
  assign slot      = 2'h3 - 2'(step_ff / 4'(arrow_entry_pkg::PHASES));
  assign phase     = 2'(step_ff % 4'(arrow_entry_pkg::PHASES));
  assign slot_data = digits_ff[slot];

  always_comb
  begin
    nxt_step = step_ff;
    if (restart)
    begin
      nxt_step = arrow_entry_pkg::STEP_RESET;
    end
    else if (advance)
    begin
      if (step_ff == arrow_entry_pkg::REFRESH_LAST)
      begin
        nxt_step = arrow_entry_pkg::STEP_RESET;
      end
      else
      begin
        nxt_step = step_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      step_ff <= arrow_entry_pkg::STEP_RESET;
    end
    else
    begin
      step_ff <= nxt_step;
    end
  end

  // Strobe: pulsed in the middle scan of each slot; the selected digit's
  // strobe stays on for its whole slot, which lights it longer as indicator
  always_comb
  begin
    strobe_act = 4'h0;
    if (phase == arrow_entry_pkg::PHASE_STROBE || slot == sel_ff)
    begin
      strobe_act = arrow_entry_pkg::one_hot(slot);
    end
  end

  // Internal logic is flipped on a mismatch, then by the output stage
  always_comb
  begin
    nxt_pins = pins_ff;
    if (restart)
    begin
      nxt_pins.bcd    = BCD_IDLE_PIN;
      nxt_pins.strobe = STROBE_IDLE_PIN;
    end
    else if (advance)
    begin
      nxt_pins.bcd    = (slot_data ^ {4{DATA_MIS}}) ^ {4{SINK_OUTPUT}};
      nxt_pins.strobe = (strobe_act ^ {4{STROBE_MIS}}) ^ {4{SINK_OUTPUT}};
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      pins_ff.bcd    <= BCD_IDLE_PIN;
      pins_ff.strobe <= STROBE_IDLE_PIN;
    end
    else
    begin
      pins_ff <= nxt_pins;
    end
  end

  // Completion pulse as the last of the twelve steps reaches the pins; that step still shows for one more scan
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= advance && (step_ff == arrow_entry_pkg::REFRESH_LAST);
    end
  end

  assign display_pins_out      = pins_ff;
  assign edited_value_word_out = value_ff;
  assign selected_digit_out    = sel_ff;
  assign config_code_out       = CFG;
  assign refresh_done_out      = done_ff;

endmodule // arrow_switch_entry
`default_nettype wire

// [verilog/scan_pacer.sv]
// Scan pacer: one-cycle tick per controller scan period.
// Assumes a free-running system clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module scan_pacer #(
  parameter int SCAN_CYCLES = arrow_entry_pkg::SCAN_CYCLES
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  output logic      scan_tick_out
);

  localparam int CW = (SCAN_CYCLES > 1) ? $clog2(SCAN_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(SCAN_CYCLES - 1);

  generate
    if (SCAN_CYCLES < 1)
    begin : g_bad_scan
      $error("scan_pacer: SCAN_CYCLES must be at least 1");
    end
  endgenerate

  logic [CW-1:0] count_ff;
  logic          tick_ff;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end
    else if (count_ff == LAST)
    begin
      count_ff <= '0;
      tick_ff  <= 1'b1;
    end
    else
    begin
      count_ff <= count_ff + CW'(1);
      tick_ff  <= 1'b0;
    end
  end

  assign scan_tick_out = tick_ff;

endmodule // scan_pacer
`default_nettype wire
